//--- tgc_consts.svh
// Register offsets, field positions, reset values and bus codes of the timer block
`ifndef TGC_CONSTS_SVH
`define TGC_CONSTS_SVH

`define TGC_ADDR_W 8
`define TGC_OFF_CTRL 8'h00
`define TGC_OFF_CFG 8'h04
`define TGC_OFF_STAT 8'h08
`define TGC_OFF_VALUE 8'h0C
`define TGC_OFF_RELOAD 8'h10
`define TGC_OFF_CAPCMP 8'h14

`define TGC_CTRL_RUN 0
`define TGC_CTRL_RUN_LO 1
`define TGC_CTRL_ONE_PULSE 2
`define TGC_CTRL_GATE_EN 3
`define TGC_CTRL_CPRE 4
`define TGC_CTRL_OE_LSB 5
`define TGC_CTRL_POL_LSB 7
`define TGC_CTRL_IRQ_EN 9

`define TGC_CFG_CS 0
`define TGC_CFG_ESF_LSB 1
`define TGC_CFG_SPLIT 3

`define TGC_STAT_OVF 0
`define TGC_STAT_MATCH 1
`define TGC_STAT_SOVF 2
`define TGC_STAT_SMATCH 3
`define TGC_STAT_IRQ 8

`define TGC_RST_WORD 16'h0000
`define TGC_ESF_NONE 2'h0
`define TGC_ESF_BOTH 2'h3

`define TGC_RESP_OKAY 2'h0
`define TGC_RESP_SLVERR 2'h2

`endif

//--- tgc_pkg.sv
// Types shared by the timer block
package tgc_pkg;

  typedef enum logic [1:0] {
    TGC_MODE_CMP,
    TGC_MODE_CAP,
    TGC_MODE_CNT,
    TGC_MODE_SPLIT
  } tgc_mode_t;

  typedef enum logic {
    TGC_SS_IDLE,
    TGC_SS_RUN
  } tgc_ss_t;

endpackage

//--- tgc_slice.sv
// One count/compare step of an auto-reload counter of parameterised width
`timescale 1ns/100ps
module tgc_slice #(
  parameter int W = 8
) (
  // Step request and current state
  input wire logic tick,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] reload,
  input wire logic [W-1:0] cmp,
  // Next state and events
  output logic [W-1:0] value_d,
  output logic ovf,
  output logic match
);

  always_comb
  begin
    ovf = tick & (&value);
    // A compare word below the reload word is never reached
    match = tick & (value == cmp) & (cmp >= reload);
    if (!tick)
    begin
      value_d = value;
    end
    else if (ovf)
    begin
      value_d = reload;
    end
    else
    begin
      value_d = value + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

//--- tgc_timer.sv
// Gated/capture/counter timer with split mode and an AXI4-Lite register slave
//
// Contract
// RL1 - Pin gates only when undriven and gate enabled
// RL2 - Gate blocks counting while pin equals polarity
// RL3 - One-pulse runs timer until overflow, then clears
// RL4 - Run plus one-pulse keeps output after pulse
// RL5 - Gated one-pulse waits for gate removal
// RL6 - After gated pulse: run continues, else stop
// RL7 - Compare mode ignores capture/reload enable
// RL8 - Edge field picks rising, falling or both
// RL9 - Capture edge reloads unless gate suppresses edge
// RL10 - Capture mode drives no pin waveform
// RL11 - Capture one-pulse starts on edge, no flag
// RL12 - Polarity picks start/end edge for two edges
// RL13 - Counter mode counts selected pin edges only
// RL14 - Overflow loads reload word, flags, requests interrupt
// RL15 - Match flag only inside reload-to-overflow range
// RL16 - Counter mode: primary input, secondary carries waveform
// RL17 - Polarity reaches pin when drive enable rises
// RL18 - Software never gates or pulses counter mode
// RL19 - Split mode makes two independent byte timers
// RL20 - Split mode routes each byte timer to pin
// RL21 - Pin equals waveform XOR latched polarity
// RL22 - Split gating affects only primary byte timer
// RL23 - Split off and no edges selects compare; code selects counter mode instead when count source select is set
// RL24 - Primary pin synchronised before any use
`timescale 1ns/100ps
`include "tgc_consts.svh"
module tgc_timer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`TGC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`TGC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer pins
  input wire logic primary_timer_pin,
  output logic primary_timer_pin_val,
  output logic primary_timer_pin_en,
  output logic secondary_timer_pin_val,
  output logic secondary_timer_pin_en,
  // Interrupt request
  output logic timer_irq
);

  // Software state
  logic primary_run_bit_q, secondary_run_bit_q, one_pulse_bit_q, gate_enable_q;
  logic capture_reload_enable_q, timer_irq_enable_q;
  logic [1:0] pin_drive_enables_q, pin_polarity_bits_q;
  logic count_source_select_q, split_mode_bit_q;
  logic [1:0] edge_select_field_q;
  logic [15:0] value_word_q, reload_word_q, capture_compare_word_q;
  logic overflow_flag_q, match_capture_flag_q, secondary_overflow_flag_q;
  logic secondary_match_flag_q;

  // Bus state
  logic [`TGC_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full_q, w_full_q;
  logic do_wr;
  logic [32:0] wr_view, rd_view;
  logic [31:0] wd;

  // Pin and timer state
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic gated_prev_q;
  logic [1:0] oe_prev_q, pol_eff_q, wave_q, toggle_q;
  tgc_pkg::tgc_ss_t ss_q;
  tgc_pkg::tgc_mode_t mode;

  // Combinational timer terms
  logic rise, fall, sel_edge, start_edge, gate_act, gated, ungate;
  logic tick16, tick_hi, tick_lo;
  logic [15:0] vd16;
  logic [7:0] vd_hi, vd_lo;
  logic ov16, m16, ov_hi, m_hi, ov_lo, m_lo;
  logic cap_start, cap_end, cap_evt, cap_reload, cap_flag, pulse_done;
  logic set_ovf, set_match, set_sovf, set_smatch;
  logic [1:0] oe_rise, toggle_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Returns {hit, word}; reserved bits read as zero
  function automatic logic [32:0] view(input logic [`TGC_ADDR_W-1:0] a);
    logic [31:0] d;
    logic hit;
    d = 32'h0000_0000;
    hit = 1'b1;
    unique case ({a[`TGC_ADDR_W-1:2], 2'h0})
      `TGC_OFF_CTRL:
      begin
        d[`TGC_CTRL_RUN] = primary_run_bit_q;
        d[`TGC_CTRL_RUN_LO] = secondary_run_bit_q;
        d[`TGC_CTRL_ONE_PULSE] = one_pulse_bit_q;
        d[`TGC_CTRL_GATE_EN] = gate_enable_q;
        d[`TGC_CTRL_CPRE] = capture_reload_enable_q;
        d[`TGC_CTRL_OE_LSB +: 2] = pin_drive_enables_q;
        d[`TGC_CTRL_POL_LSB +: 2] = pin_polarity_bits_q;
        d[`TGC_CTRL_IRQ_EN] = timer_irq_enable_q;
      end
      `TGC_OFF_CFG:
      begin
        d[`TGC_CFG_CS] = count_source_select_q;
        d[`TGC_CFG_ESF_LSB +: 2] = edge_select_field_q;
        d[`TGC_CFG_SPLIT] = split_mode_bit_q;
      end
      `TGC_OFF_STAT:
      begin
        d[`TGC_STAT_OVF] = overflow_flag_q;
        d[`TGC_STAT_MATCH] = match_capture_flag_q;
        d[`TGC_STAT_SOVF] = secondary_overflow_flag_q;
        d[`TGC_STAT_SMATCH] = secondary_match_flag_q;
        d[`TGC_STAT_IRQ] = timer_irq;
      end
      `TGC_OFF_VALUE: d[15:0] = value_word_q;
      `TGC_OFF_RELOAD: d[15:0] = reload_word_q;
      `TGC_OFF_CAPCMP: d[15:0] = capture_compare_word_q;
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_view = view(aw_addr_q);
  assign rd_view = view(s_axi_araddr);
  assign wd = merge(wr_view[31:0], w_data_q, w_strb_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else
    begin
      if (do_wr)
      begin
        aw_full_q <= 1'b0;
      end
      s_axi_awready <= ~aw_full_q & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else
    begin
      if (do_wr)
      begin
        w_full_q <= 1'b0;
      end
      s_axi_wready <= ~w_full_q & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TGC_RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_view[32] ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TGC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_view[31:0];
      s_axi_rresp <= rd_view[32] ? `TGC_RESP_OKAY : `TGC_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid <= ~s_axi_rready;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  logic wr_ctrl, wr_cfg, wr_stat, wr_value, wr_reload, wr_capcmp;
  assign wr_ctrl = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_CTRL);
  assign wr_cfg = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_CFG);
  assign wr_stat = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_STAT);
  assign wr_value = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_VALUE);
  assign wr_reload = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_RELOAD);
  assign wr_capcmp = do_wr & ({aw_addr_q[`TGC_ADDR_W-1:2], 2'h0} == `TGC_OFF_CAPCMP);
  // Clears come from written bytes only, so an unstrobed byte never clears a set flag
  logic [3:0] stat_clr;
  assign stat_clr = {4{wr_stat & w_strb_q[0]}} & w_data_q[3:0];

  // ---------------- Pin conditioning ----------------
  // RL24 synchronise primary pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= primary_timer_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_comb
  begin
    // RL23 mode decode
    if (split_mode_bit_q)
      mode = tgc_pkg::TGC_MODE_SPLIT;
    else if (count_source_select_q)
      mode = tgc_pkg::TGC_MODE_CNT;
    else if (edge_select_field_q != `TGC_ESF_NONE)
      mode = tgc_pkg::TGC_MODE_CAP;
    else
      mode = tgc_pkg::TGC_MODE_CMP;
    rise = pin_s2_q & ~pin_s3_q;
    fall = ~pin_s2_q & pin_s3_q;
    // RL8 edge selection
    sel_edge = (edge_select_field_q[0] & rise) | (edge_select_field_q[1] & fall);
    // RL12 start/end edge for two-edge capture
    start_edge = (edge_select_field_q == `TGC_ESF_BOTH)
                 ? (pin_polarity_bits_q[0] ? fall : rise) : sel_edge;
    // RL1 gate only with undriven pin; counter mode has no gating
    gate_act = gate_enable_q & ~pin_drive_enables_q[0] & (mode != tgc_pkg::TGC_MODE_CNT);
    // RL2 block while pin equals polarity
    gated = gate_act & (pin_s2_q == pin_polarity_bits_q[0]);
    ungate = gate_act & gated_prev_q & ~gated;
  end

  // ---------------- Count enables ----------------
  always_comb
  begin
    tick16 = 1'b0;
    tick_hi = 1'b0;
    tick_lo = 1'b0;
    unique case (mode)
      // RL3 RL5 RL6 one-pulse overrides stopped run, gate holds it
      tgc_pkg::TGC_MODE_CMP: tick16 = (primary_run_bit_q | one_pulse_bit_q) & ~gated;
      tgc_pkg::TGC_MODE_CAP:
        tick16 = (primary_run_bit_q | (ss_q == tgc_pkg::TGC_SS_RUN)) & ~gated;
      // RL13 counter advances on selected edges only
      tgc_pkg::TGC_MODE_CNT: tick16 = sel_edge;
      tgc_pkg::TGC_MODE_SPLIT:
      begin
        // RL22 only primary byte timer is gated
        tick_hi = (primary_run_bit_q | one_pulse_bit_q) & ~gated;
        tick_lo = secondary_run_bit_q;
      end
    endcase
  end

  // RL19 split into independent byte timers
  tgc_slice #(.W(16)) u_full (
    .tick(tick16), .value(value_word_q), .reload(reload_word_q),
    .cmp(capture_compare_word_q), .value_d(vd16), .ovf(ov16), .match(m16));
  tgc_slice #(.W(8)) u_high (
    .tick(tick_hi), .value(value_word_q[15:8]), .reload(reload_word_q[15:8]),
    .cmp(capture_compare_word_q[15:8]), .value_d(vd_hi), .ovf(ov_hi), .match(m_hi));
  tgc_slice #(.W(8)) u_low (
    .tick(tick_lo), .value(value_word_q[7:0]), .reload(reload_word_q[7:0]),
    .cmp(capture_compare_word_q[7:0]), .value_d(vd_lo), .ovf(ov_lo), .match(m_lo));

  // ---------------- Capture ----------------
  always_comb
  begin
    // RL11 start on defined edge or removal of gate
    cap_start = (mode == tgc_pkg::TGC_MODE_CAP) & one_pulse_bit_q
                & (ss_q == tgc_pkg::TGC_SS_IDLE) & (start_edge | ungate);
    cap_end = (mode == tgc_pkg::TGC_MODE_CAP) & (ss_q == tgc_pkg::TGC_SS_RUN) & start_edge;
    cap_evt = (mode == tgc_pkg::TGC_MODE_CAP) & sel_edge
              & (primary_run_bit_q | one_pulse_bit_q);
    // RL9 RL12 gating suppresses reload on the opposite edge
    // RL7 reload enable only used in capture mode
    cap_reload = cap_evt & capture_reload_enable_q
                 & ~(gate_act & (pin_polarity_bits_q[0] ? rise : fall));
    // RL11 starting edge raises no flag
    cap_flag = cap_evt & ~cap_start;
    // RL3 one-pulse ends on overflow, or on the end edge in capture mode
    pulse_done = ((mode == tgc_pkg::TGC_MODE_CMP) & ov16)
                 | ((mode == tgc_pkg::TGC_MODE_SPLIT) & ov_hi) | cap_end;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ss_q <= tgc_pkg::TGC_SS_IDLE;
    else if (mode != tgc_pkg::TGC_MODE_CAP || cap_end)
      ss_q <= tgc_pkg::TGC_SS_IDLE;
    else if (cap_start)
      ss_q <= tgc_pkg::TGC_SS_RUN;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gated_prev_q <= 1'b0;
    else
      gated_prev_q <= gated;
  end

  // ---------------- Software registers ----------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_run_bit_q <= 1'b0;
      secondary_run_bit_q <= 1'b0;
      gate_enable_q <= 1'b0;
      capture_reload_enable_q <= 1'b0;
      pin_drive_enables_q <= 2'h0;
      pin_polarity_bits_q <= 2'h0;
      timer_irq_enable_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      primary_run_bit_q <= wd[`TGC_CTRL_RUN];
      secondary_run_bit_q <= wd[`TGC_CTRL_RUN_LO];
      gate_enable_q <= wd[`TGC_CTRL_GATE_EN];
      capture_reload_enable_q <= wd[`TGC_CTRL_CPRE];
      pin_drive_enables_q <= wd[`TGC_CTRL_OE_LSB +: 2];
      pin_polarity_bits_q <= wd[`TGC_CTRL_POL_LSB +: 2];
      timer_irq_enable_q <= wd[`TGC_CTRL_IRQ_EN];
    end
  end

  // Software write wins over the hardware clear of the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      one_pulse_bit_q <= 1'b0;
    else if (wr_ctrl)
      one_pulse_bit_q <= wd[`TGC_CTRL_ONE_PULSE];
    else if (pulse_done)
      one_pulse_bit_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_source_select_q <= 1'b0;
      edge_select_field_q <= 2'h0;
      split_mode_bit_q <= 1'b0;
    end
    else if (wr_cfg)
    begin
      count_source_select_q <= wd[`TGC_CFG_CS];
      edge_select_field_q <= wd[`TGC_CFG_ESF_LSB +: 2];
      split_mode_bit_q <= wd[`TGC_CFG_SPLIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      value_word_q <= `TGC_RST_WORD;
    else if (wr_value)
      value_word_q <= wd[15:0];
    else if (mode == tgc_pkg::TGC_MODE_SPLIT)
      value_word_q <= {vd_hi, vd_lo};
    else if (cap_reload)
      value_word_q <= reload_word_q;
    else
      // RL14 overflow loads reload word
      value_word_q <= vd16;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reload_word_q <= `TGC_RST_WORD;
    else if (wr_reload)
      reload_word_q <= wd[15:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      capture_compare_word_q <= `TGC_RST_WORD;
    else if (wr_capcmp)
      capture_compare_word_q <= wd[15:0];
    else if (cap_evt)
      capture_compare_word_q <= value_word_q;
  end

  // ---------------- Flags and interrupt ----------------
  always_comb
  begin
    set_ovf = (mode == tgc_pkg::TGC_MODE_SPLIT) ? ov_hi : ov16;
    // RL15 range check lives in the slice compare
    set_match = (mode == tgc_pkg::TGC_MODE_SPLIT) ? m_hi
              : (((mode != tgc_pkg::TGC_MODE_CAP) & m16) | cap_flag);
    set_sovf = (mode == tgc_pkg::TGC_MODE_SPLIT) & ov_lo;
    set_smatch = (mode == tgc_pkg::TGC_MODE_SPLIT) & m_lo;
  end

  // RL14 flags: hardware set wins over write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overflow_flag_q <= 1'b0;
      match_capture_flag_q <= 1'b0;
      secondary_overflow_flag_q <= 1'b0;
      secondary_match_flag_q <= 1'b0;
    end
    else
    begin
      overflow_flag_q <= set_ovf | (overflow_flag_q & ~stat_clr[`TGC_STAT_OVF]);
      match_capture_flag_q <= set_match
                              | (match_capture_flag_q & ~stat_clr[`TGC_STAT_MATCH]);
      secondary_overflow_flag_q <= set_sovf
                              | (secondary_overflow_flag_q & ~stat_clr[`TGC_STAT_SOVF]);
      secondary_match_flag_q <= set_smatch
                              | (secondary_match_flag_q & ~stat_clr[`TGC_STAT_SMATCH]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_irq <= 1'b0;
    else
      timer_irq <= timer_irq_enable_q & (overflow_flag_q | match_capture_flag_q
                   | secondary_overflow_flag_q | secondary_match_flag_q);
  end

  // ---------------- Waveform and pins ----------------
  assign oe_rise = pin_drive_enables_q & ~oe_prev_q;
  // Match at overflow gives a single toggle because both events merge here
  assign toggle_d = (mode == tgc_pkg::TGC_MODE_SPLIT) ? {ov_lo | m_lo, ov_hi | m_hi}
                  : {2{(ov16 | m16) & (mode != tgc_pkg::TGC_MODE_CAP)}};

  // RL17 RL21 polarity latched when drive enable rises, waveform restarts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      oe_prev_q <= 2'h0;
      pol_eff_q <= 2'h0;
      toggle_q <= 2'h0;
      wave_q <= 2'h0;
    end
    else
    begin
      oe_prev_q <= pin_drive_enables_q;
      toggle_q <= toggle_d;
      for (int n = 0; n < 2; n++)
      begin
        if (oe_rise[n])
        begin
          pol_eff_q[n] <= pin_polarity_bits_q[n];
          wave_q[n] <= 1'b0;
        end
        else
        begin
          wave_q[n] <= wave_q[n] ^ toggle_q[n];
        end
      end
    end
  end

  // RL4 output follows the running timer after the pulse clears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      primary_timer_pin_val <= 1'b0;
      primary_timer_pin_en <= 1'b0;
      secondary_timer_pin_val <= 1'b0;
      secondary_timer_pin_en <= 1'b0;
    end
    else
    begin
      primary_timer_pin_val <= wave_q[0] ^ pol_eff_q[0];
      secondary_timer_pin_val <= wave_q[1] ^ pol_eff_q[1];
      // RL10 RL16 RL20 pin routing per mode
      primary_timer_pin_en <= pin_drive_enables_q[0]
                              & (mode != tgc_pkg::TGC_MODE_CAP)
                              & (mode != tgc_pkg::TGC_MODE_CNT);
      secondary_timer_pin_en <= pin_drive_enables_q[1] & (mode != tgc_pkg::TGC_MODE_CAP);
    end
  end

endmodule

//--- tgc_timer_checker.sv
// Bus handshake checks on the timer block ports
`timescale 1ns/100ps
module tgc_timer_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  read_answer_a: assert property (read_taken |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule

//--- tgc_pin_model.sv
// Outside source of the primary pin: levels and pulse trains
`timescale 1ns/100ps
module tgc_pin_model (
  // Clock
  input wire logic aclk,
  // Pin level
  output logic pin
);
  initial pin = 1'b0;
  task automatic pulses(input int n, input int w);
    repeat (n)
    begin
      repeat (w) @(posedge aclk);
      pin <= 1'b1;
      repeat (w) @(posedge aclk);
      pin <= 1'b0;
    end
  endtask
  task automatic level(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask
endmodule

//--- timer_gate_capture_count_tb.sv
// Self-checking bench of the timer block
`timescale 1ns/100ps
`include "tgc_consts.svh"
module timer_gate_capture_count_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pen, pval, sen, sval, irq, pin;
  logic [1:0] bresp, rresp;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  logic [15:0] r;
  int bad_count = 0, n_checks = 0;
  always #2.5 aclk = ~aclk;
  tgc_timer i_tgc_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .primary_timer_pin(pin), .primary_timer_pin_val(pval),
    .primary_timer_pin_en(pen), .secondary_timer_pin_val(sval),
    .secondary_timer_pin_en(sen), .timer_irq(irq));
  tgc_pin_model i_tgc_pin_model (.aclk(aclk), .pin(pin));
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = 2'h0);
    expq.push_back({re, e});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    @(posedge aclk);
  endtask
  // Results are compared where they appear
  always @(posedge aclk)
  begin
    if (rvalid && rready)
      chk({rresp, rdata}, expq.pop_front());
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'hE344));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`TGC_OFF_CTRL, 0);
    rd(8'h18, 0, `TGC_RESP_SLVERR);
    wr(8'h18, 1, `TGC_RESP_SLVERR);
    wr(`TGC_OFF_RELOAD, 32'h1234);
    wr(`TGC_OFF_VALUE, 32'hFFF0);
    wr(`TGC_OFF_CTRL, 32'h201);
    repeat (40) @(posedge aclk);
    chk(irq, 1);
    wr(`TGC_OFF_CTRL, 0);
    rd(`TGC_OFF_STAT, 1);
    wr(`TGC_OFF_STAT, 1);
    r = 16'h2000 + 16'($urandom & 32'hFFF);
    wr(`TGC_OFF_CAPCMP, r + 3);
    wr(`TGC_OFF_CTRL, 1);
    // Counter mode: never gated nor one-pulse here
    for (int s = 0; s < 4; s++)
    begin
      wr(`TGC_OFF_CFG, 1 + 2 * s);
      wr(`TGC_OFF_VALUE, r);
      i_tgc_pin_model.pulses(5, 3);
      repeat (10) @(posedge aclk);
      rd(`TGC_OFF_VALUE, r + (s == 0 ? 0 : s == 3 ? 10 : 5));
    end
    rd(`TGC_OFF_STAT, 2);
    wr(`TGC_OFF_CTRL, 0);
    wr(`TGC_OFF_CFG, 0);
    for (int p = 0; p < 2; p++)
    begin
      i_tgc_pin_model.level(p[0]);
      wr(`TGC_OFF_CTRL, 32'h9 + 32'h80 * p);
      wr(`TGC_OFF_VALUE, r);
      repeat (20) @(posedge aclk);
      rd(`TGC_OFF_VALUE, r);
    end
    wr(`TGC_OFF_CTRL, 0);
    wr(`TGC_OFF_VALUE, 32'hFFF8);
    wr(`TGC_OFF_CTRL, 4);
    repeat (40) @(posedge aclk);
    rd(`TGC_OFF_CTRL, 0);
    rd(`TGC_OFF_VALUE, 32'h1234);
    // Both pins enabled with high polarity, timer stopped
    wr(`TGC_OFF_CTRL, 32'h1E0);
    repeat (4) @(posedge aclk);
    chk({pen, pval, sen, sval}, 4'hF);
    // New polarity must not reach the pins while enables stay on
    wr(`TGC_OFF_CTRL, 32'h60);
    wr(`TGC_OFF_VALUE, 32'hFFFE);
    wr(`TGC_OFF_CTRL, 32'h64);
    repeat (20) @(posedge aclk);
    chk({pen, pval, sen, sval}, 4'hA);
    wr(`TGC_OFF_CFG, 32'h2);
    repeat (4) @(posedge aclk);
    chk({pen, sen}, 0);
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule
bind tgc_timer tgc_timer_checker i_tgc_timer_checker (.*);
